// >>> stnc_core.sv
// Sub-audio tone and NRZ codec core with Avalon-MM register slave
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "stnc_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
module stnc_core
  import stnc_pkg::*;
#(
  parameter int unsigned GATE_CYC   = `STNC_GATE_US * `STNC_CLK_MHZ,
  parameter int unsigned NOTONE_CYC = `STNC_NOTONE_US * `STNC_CLK_MHZ
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_wake,
  input  wire logic        i_cmp_in,
  output logic             o_cmp_out,
  output logic             o_tx_data,
  output logic             o_tx_bias,
  output logic             o_tx_emph,
  output logic [7:0]       o_tx_gain,
  output logic [3:0]       o_tx_band,
  output logic             o_sleep,
  output logic             o_notone,
  output logic             o_irq
);

  stnc_state_t q;
  stnc_state_t d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] w;
  logic        tick;
  logic        edge_r;
  logic        edge_a;
  logic [19:0] dif;
  logic        good_c;

  always_comb begin
    d      = q;
    // Side effects land only at the edge where waitrequest is seen low
    acc    = (i_read | i_write) & ~q.wait_n;
    wr     = i_write & acc;
    rd     = i_read & acc;
    w      = 32'h0000_0000;
    tick   = 1'b0;
    edge_r = 1'b0;
    edge_a = 1'b0;
    dif    = 20'h00000;
    good_c = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    d.wake_m = i_wake;
    d.wake_s = q.wake_m;
    d.cmp_m  = i_cmp_in;
    d.cmp_s  = q.cmp_m;

    // Sleep is the registered AND of the synchronised pin and the bit, so either party wakes it
    d.sleep = q.ctrl[`STNC_CTRL_SLEEP] & q.wake_s;

    //////////////////////////////////////////////////////////////////////////
    // Comparator node and noise filter
    if (!q.ctrl[`STNC_CTRL_TONERX] && !q.ctrl[`STNC_CTRL_NRZRX] || q.sleep) begin
      d.node = 1'b0;
    end else begin
      d.node = q.cmp_s;
    end
    d.filt_sh = {q.filt_sh[1:0], q.node};
    // Output changes only on three equal samples, rejecting single-sample glitches at the cost of latency
    if (q.filt_sh == 3'b111) begin
      d.filt = 1'b1;
    end else if (q.filt_sh == 3'b000) begin
      d.filt = 1'b0;
    end
    edge_a = d.filt != q.filt;
    edge_r = d.filt & ~q.filt;

    //////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then the access completes
    d.wait_n = ~((i_read | i_write) & q.wait_n);
    d.rdata  = 32'h0000_0000;
    if (i_read | i_write) begin
      unique case (i_address)
        `STNC_OFS_CTRL:   d.rdata = {24'h000000, q.ctrl};
        `STNC_OFS_STATUS: d.rdata = {26'h0000000, q.tx_st == TX_SHIFT, q.tx_full, q.rx_rdy,
                                     q.irq, q.notone, q.sleep};
        `STNC_OFS_TXFREQ: d.rdata = {16'h0000, q.band, 1'b0, q.tone_q};
        `STNC_OFS_BAUD:   d.rdata = {q.rx_div, q.tx_div};
        `STNC_OFS_RXFREQ: d.rdata = {16'h0000, q.rx_freq};
        `STNC_OFS_RXDATA: d.rdata = {24'h000000, q.rx_data};
        `STNC_OFS_GAIN:   d.rdata = {24'h000000, q.gain};
        default:          d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (i_address)
        `STNC_OFS_CTRL: begin
          w      = merge({24'h000000, q.ctrl}, i_writedata, i_byteenable);
          d.ctrl = w[7:0];
        end
        `STNC_OFS_TXFREQ: begin
          w        = merge({16'h0000, q.band, 1'b0, q.tone_q}, i_writedata, i_byteenable);
          d.tone_q = w[10:0];
          d.band   = w[15:12];
        end
        `STNC_OFS_BAUD: begin
          w        = merge({q.rx_div, q.tx_div}, i_writedata, i_byteenable);
          d.tx_div = w[15:0];
          d.rx_div = w[31:16];
        end
        `STNC_OFS_TXDATA: begin
          if (i_byteenable[0]) begin
            d.tx_buf  = i_writedata[7:0];
            d.tx_full = 1'b1;
          end
        end
        `STNC_OFS_GAIN: begin
          if (i_byteenable[0]) begin
            d.gain = i_writedata[7:0];
          end
        end
        `STNC_OFS_STATUS: begin
          if (i_byteenable[0] && i_writedata[`STNC_ST_IRQ]) begin
            d.irq = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd && i_address == `STNC_OFS_RXDATA) begin
      d.rx_rdy = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Tone encoder: square wave, half period of tone_q + 1 ticks
    if (q.tick_cnt >= `STNC_TONE_TICK_CYC - 10'd1) begin
      d.tick_cnt = 10'h000;
      tick       = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 10'd1;
    end
    if (tick) begin
      if (q.tone_cnt >= q.tone_q) begin
        d.tone_cnt = 11'h000;
        d.tone_sq  = ~q.tone_sq;
      end else begin
        d.tone_cnt = q.tone_cnt + 11'd1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // NRZ encoder, MSB first
    unique case (q.tx_st)
      TX_IDLE: begin
        if (q.tx_full && q.ctrl[`STNC_CTRL_TXEN] && !q.ctrl[`STNC_CTRL_TXTONE] && !q.sleep) begin
          d.tx_sh   = q.tx_buf;
          d.tx_full = d.tx_full & ~q.tx_full | (wr && i_address == `STNC_OFS_TXDATA);
          d.tx_bit  = 3'd7;
          d.tx_cnt  = 16'h0000;
          d.tx_emph = q.ctrl[`STNC_CTRL_EMPH] & (q.tx_buf[7] != q.tx_out);
          d.tx_out  = q.tx_buf[7];
          d.tx_st   = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (q.tx_cnt >= q.tx_div) begin
          d.tx_cnt = 16'h0000;
          if (q.tx_bit == 3'd0) begin
            d.tx_st = TX_IDLE;
          end else begin
            d.tx_sh   = {q.tx_sh[6:0], 1'b0};
            d.tx_bit  = q.tx_bit - 3'd1;
            d.tx_out  = q.tx_sh[6];
            d.tx_emph = q.ctrl[`STNC_CTRL_EMPH] & (q.tx_sh[6] != q.tx_out);
          end
        end else begin
          d.tx_cnt = q.tx_cnt + 16'd1;
        end
      end
    endcase
    if (q.sleep) begin
      d.tx_st = TX_IDLE;
    end

    // Output mux: tone square wave or NRZ bit, both leaving via the gain stage
    if (q.ctrl[`STNC_CTRL_TXTONE]) begin
      d.tx_data = q.tone_sq;
    end else begin
      d.tx_data = q.tx_out;
    end
    d.tx_bias = q.sleep | ~q.ctrl[`STNC_CTRL_TXEN]
              | (~q.ctrl[`STNC_CTRL_TXTONE] & (q.tx_st == TX_IDLE));

    //////////////////////////////////////////////////////////////////////////
    // NRZ receiver: counter realigns on each data edge, samples mid-bit
    if (q.ctrl[`STNC_CTRL_NRZRX] && !q.sleep) begin
      if (edge_a) begin
        d.rx_cnt = {1'b0, q.rx_div[15:1]};
      end else if (q.rx_cnt >= q.rx_div) begin
        d.rx_cnt = 16'h0000;
        d.rx_sh  = {q.rx_sh[6:0], q.filt};
        d.rx_bit = q.rx_bit + 3'd1;
        if (q.rx_bit == 3'd7) begin
          d.rx_data = {q.rx_sh[6:0], q.filt};
          d.rx_rdy  = 1'b1;
        end
      end else begin
        d.rx_cnt = q.rx_cnt + 16'd1;
      end
    end else begin
      d.rx_cnt = 16'h0000;
      d.rx_bit = 3'd0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Tone receiver, independent of the NRZ receiver so both may run
    if (q.ctrl[`STNC_CTRL_TONERX] && !q.sleep) begin
      d.per_cnt = (q.per_cnt == 20'hFFFFF) ? q.per_cnt : q.per_cnt + 20'd1;
      if (edge_r) begin
        dif    = (q.per_cnt > q.per_prev) ? q.per_cnt - q.per_prev : q.per_prev - q.per_cnt;
        good_c = dif <= (q.per_prev >> `STNC_QUAL_SHIFT);
        d.per_prev = q.per_cnt;
        d.per_cnt  = 20'h00000;
        d.edges    = q.edges + 16'd1;
        d.good     = q.good + {15'h0000, good_c};
      end
      if (q.gate_cnt >= 23'(GATE_CYC - 1)) begin
        d.gate_cnt = 23'h000000;
        d.edges    = 16'h0000;
        d.good     = 16'h0000;
        // At least half of the cycles must pass the variance test
        if (q.good == 16'h0000 || {q.good, 1'b0} < q.edges) begin
          d.notone = 1'b1;
        end else begin
          d.notone  = 1'b0;
          d.rx_freq = q.edges;
        end
      end else begin
        d.gate_cnt = q.gate_cnt + 23'd1;
      end
    end else begin
      d.gate_cnt = 23'h000000;
      d.edges    = 16'h0000;
      d.good     = 16'h0000;
    end

    // Tone-absent timer; a clear in the same cycle as expiry loses to the set
    if (q.ctrl[`STNC_CTRL_TONERX] && !q.sleep && q.notone) begin
      if (q.nt_cnt >= 24'(NOTONE_CYC - 1)) begin
        d.nt_cnt = 24'h000000;
        d.irq    = 1'b1;
      end else begin
        d.nt_cnt = q.nt_cnt + 24'd1;
      end
    end else begin
      d.nt_cnt = 24'h000000;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q        <= '0;
      q.wait_n <= 1'b1;
      q.ctrl   <= `STNC_CTRL_RST;
      q.tx_div <= `STNC_BAUD_RST;
      q.rx_div <= 16'h0000;
      q.tx_st  <= TX_IDLE;
      q.tx_bias <= 1'b1;
    end else begin
      q         <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign o_readdata    = q.rdata;
  assign o_waitrequest = q.wait_n;
  assign o_cmp_out     = q.node;
  assign o_tx_data     = q.tx_data;
  assign o_tx_bias     = q.tx_bias;
  assign o_tx_emph     = q.tx_emph;
  assign o_tx_gain     = q.gain;
  assign o_tx_band     = q.band;
  assign o_sleep       = q.sleep;
  assign o_notone      = q.notone;
  assign o_irq         = q.irq;

endmodule : stnc_core

// >>> stnc_cfg.svh
// Offsets, field positions, reset values and timing counts of the sub-audio codec
`ifndef STNC_CFG_SVH
`define STNC_CFG_SVH
`define STNC_CLK_MHZ      50
`define STNC_OFS_CTRL     8'h00
`define STNC_OFS_STATUS   8'h04
`define STNC_OFS_TXFREQ   8'h08
`define STNC_OFS_BAUD     8'h0C
`define STNC_OFS_RXFREQ   8'h10
`define STNC_OFS_RXDATA   8'h14
`define STNC_OFS_TXDATA   8'h18
`define STNC_OFS_GAIN     8'h1C
`define STNC_CTRL_SLEEP   0
`define STNC_CTRL_TXEN    1
`define STNC_CTRL_TXTONE  2
`define STNC_CTRL_EMPH    3
`define STNC_CTRL_TONERX  4
`define STNC_CTRL_NRZRX   5
`define STNC_ST_SLEEP     0
`define STNC_ST_NOTONE    1
`define STNC_ST_IRQ       2
`define STNC_ST_RXRDY     3
`define STNC_ST_TXFULL    4
`define STNC_ST_TXBUSY    5
`define STNC_CTRL_RST     8'h00
`define STNC_BAUD_RST     16'h0000
`define STNC_TONE_TICK_NS 1000
`define STNC_TONE_TICK_CYC 10'((`STNC_TONE_TICK_NS * `STNC_CLK_MHZ) / 1000)
`define STNC_GATE_US      122640
`define STNC_NOTONE_US    250000
`define STNC_QUAL_SHIFT   4
`define STNC_FILT_LEN     3
`endif

// >>> stnc_pkg.sv
// Types shared by the sub-audio codec
package stnc_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} stnc_tx_t;
  typedef struct packed {
    logic        wake_m;
    logic        wake_s;
    logic        cmp_m;
    logic        cmp_s;
    logic [2:0]  filt_sh;
    logic        filt;
    logic        node;
    logic        wait_n;
    logic [31:0] rdata;
    logic [7:0]  ctrl;
    logic [10:0] tone_q;
    logic [3:0]  band;
    logic [15:0] tx_div;
    logic [15:0] rx_div;
    logic [7:0]  gain;
    logic        sleep;
    logic [9:0]  tick_cnt;
    logic [10:0] tone_cnt;
    logic        tone_sq;
    stnc_tx_t    tx_st;
    logic [7:0]  tx_buf;
    logic        tx_full;
    logic [7:0]  tx_sh;
    logic [2:0]  tx_bit;
    logic [15:0] tx_cnt;
    logic        tx_emph;
    logic        tx_bias;
    logic        tx_out;
    logic        tx_data;
    logic [15:0] rx_cnt;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_data;
    logic        rx_rdy;
    logic [19:0] per_cnt;
    logic [19:0] per_prev;
    logic [22:0] gate_cnt;
    logic [15:0] edges;
    logic [15:0] good;
    logic [15:0] rx_freq;
    logic        notone;
    logic [23:0] nt_cnt;
    logic        irq;
  } stnc_state_t;
endpackage : stnc_pkg

// >>> stnc_core_chk.sv
// Port-level assertions for the sub-audio codec core
`timescale 1ns/1ps
module stnc_core_chk (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0]  i_byteenable,
  input wire logic        o_waitrequest,
  input wire logic        i_wake,
  input wire logic        i_cmp_in,
  input wire logic        o_cmp_out,
  input wire logic        o_tx_bias,
  input wire logic        o_sleep,
  input wire logic        o_notone,
  input wire logic        o_irq
);
  logic       wr_ok;
  logic [5:0] ctrl_q;
  assign wr_ok = i_write && !o_waitrequest;
  // Shadow of the control bits, since the checker cannot see inside
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= 6'h00;
    end else if (wr_ok && i_address == 8'h00 && i_byteenable[0]) begin
      ctrl_q <= i_writedata[5:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_WAIT_ANSWER:
    assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered in one cycle");
  AST_WAIT_PULSE:
    assert property (!o_waitrequest |=> o_waitrequest) else $error("answer held too long");
  AST_SLEEP_ENTER:
    assert property ((ctrl_q[0] && i_wake) [*5] |-> o_sleep) else $error("sleep not entered");
  AST_SLEEP_WAKE:
    assert property (!i_wake [*4] |-> !o_sleep) else $error("asleep with wake pin low");
  AST_SLEEP_BIT:
    assert property (!ctrl_q[0] [*3] |-> !o_sleep) else $error("asleep with sleep bit low");
  AST_BIAS_SLEEP:
    assert property (o_sleep [*3] |-> o_tx_bias) else $error("output off bias in sleep");
  AST_NODE_OFF:
    assert property (!(ctrl_q[4] || ctrl_q[5]) [*3] |-> !o_cmp_out) else $error("node not low");
  AST_NODE_FEED:
    assert property ((ctrl_q[4] && !o_sleep && i_cmp_in) [*7] |-> o_cmp_out)
    else $error("node does not follow comparator");
  AST_IRQ_CAUSE:
    assert property ($rose(o_irq) |-> o_notone) else $error("interrupt without tone absence");
  AST_IRQ_MODE:
    assert property ($rose(o_irq) |-> ctrl_q[4]) else $error("interrupt outside tone receive");
  cover property ($rose(o_sleep));
  cover property ($rose(o_irq));
  cover property (wr_ok && i_address == 8'h00);
endmodule : stnc_core_chk

bind stnc_core stnc_core_chk stnc_core_chk_inst (.i_clk, .i_rst, .i_address, .i_read, .i_write,
  .i_writedata, .i_byteenable, .o_waitrequest, .i_wake, .i_cmp_in, .o_cmp_out, .o_tx_bias,
  .o_sleep, .o_notone, .o_irq);

// >>> stnc_tone_src.sv
// Far-end comparator model: square wave toggling every half period
`timescale 1ns/1ps
module stnc_tone_src (
  input  wire logic        i_clk,
  input  wire logic        i_en,
  input  wire logic [15:0] i_half,
  output logic             o_sig
);
  logic [15:0] cnt_q = 16'h0000;
  initial o_sig = 1'b0;
  // A quiet comparator sits low, so a disabled source gives no edges
  always @(posedge i_clk) begin
    if (!i_en) begin
      cnt_q <= 16'h0000;
      o_sig <= 1'b0;
    end else if (cnt_q == i_half - 16'h0001) begin
      cnt_q <= 16'h0000;
      o_sig <= ~o_sig;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : stnc_tone_src

// >>> stnc_core_tb.sv
// Self-checking bench for the sub-audio codec core
`timescale 1ns/1ps
module stnc_core_tb;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_address = 8'h00;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0]  i_byteenable = 4'hF;
  logic        i_wake = 1'b0;
  logic        src_en = 1'b0;
  logic [15:0] src_half = 16'h8;
  logic [31:0] o_readdata, rd;
  logic        o_waitrequest, i_cmp_in, o_cmp_out, o_tx_data, o_tx_bias, o_tx_emph;
  logic        o_sleep, o_notone, o_irq;
  logic [7:0]  o_tx_gain;
  logic [3:0]  o_tx_band;
  int          num_errors = 0;
  int          n_compared = 0;
  int          emph_n, len;

  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_tx_emph === 1'b1) emph_n++;
  end

  // Short gate and timer so a tone measurement fits in a few thousand cycles
  stnc_core #(.GATE_CYC(2000), .NOTONE_CYC(500)) stnc_core_inst (.i_clk, .i_rst, .i_address,
    .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest, .i_wake,
    .i_cmp_in, .o_cmp_out, .o_tx_data, .o_tx_bias, .o_tx_emph, .o_tx_gain, .o_tx_band,
    .o_sleep, .o_notone, .o_irq);
  stnc_tone_src stnc_tone_src_inst (.i_clk, .i_en(src_en), .i_half(src_half), .o_sig(i_cmp_in));
  ////////////////////////////////////////
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One bus access; the host sets the pace, the slave answers when ready
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_address <= a;
    i_writedata <= d;
    i_read <= !wr;
    i_write <= wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    rd = o_readdata;
    if (n >= 50) begin
      check("bus timeout", 32'h1, 32'h0);
      end_sim();
    end
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask : acc

  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      acc(1'b0, 8'h04, 32'h0);
      n++;
    end while (rd[b] !== v && n < 3000);
    check("status wait", rd[b], v);
  endtask : wait_st

  // Length of the next whole high run on the transmit line, in clocks
  task automatic hi_len(output int l);
    int n;
    n = 0;
    while (o_tx_data === 1'b1 && n < 4000) begin @(posedge i_clk); n++; end
    while (o_tx_data !== 1'b1 && n < 8000) begin @(posedge i_clk); n++; end
    l = 0;
    while (o_tx_data === 1'b1 && l < 4000) begin @(posedge i_clk); l++; end
  endtask : hi_len
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check("reset bias", o_tx_bias, 1'h1);
    acc(1'b1, 8'h08, 32'h0000_A7FF);
    acc(1'b0, 8'h08, 32'h0);
    check("tx word", rd[15:0], 16'hA7FF);
    check("band", o_tx_band, 4'hA);
    acc(1'b1, 8'h1C, 32'h5A);
    check("gain", o_tx_gain, 8'h5A);
    acc(1'b0, 8'h30, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    acc(1'b1, 8'h0C, 32'h0007_0003);
    for (int e = 0; e < 2; e++) begin
      acc(1'b1, 8'h00, {28'h0, e[0], 3'h2});
      emph_n = 0;
      acc(1'b1, 8'h18, 32'h37);
      hi_len(len);
      check("nrz run", len, 32'h8);
      wait_st(5, 1'b0);
      check("idle bias", o_tx_bias, 1'h1);
      check("emphasis", emph_n != 0, e[0]);
    end
    $display("test nrz transmit done");
    acc(1'b1, 8'h08, 32'h0000_A001);
    acc(1'b1, 8'h00, 32'h06);
    hi_len(len);
    check("tone half period", len, 32'h64);
    $display("test tone transmit done");
    for (int s = 0; s < 4; s++) begin
      i_wake <= (s != 1);
      acc(1'b1, 8'h00, {31'h0, s < 3});
      repeat (4) @(posedge i_clk);
      check("sleep", {o_tx_bias & o_sleep, o_sleep}, {2{s[0] == 0 && s < 3}});
    end
    $display("test sleep done");
    src_en <= 1'b1;
    acc(1'b1, 8'h00, 32'h30);
    for (int r = 0; r < 2; r++) begin
      wait_st(3, 1'b1);
      acc(1'b0, 8'h14, 32'h0);
    end
    check("rx byte", rd[7:0] inside {8'hAA, 8'h55}, 1'h1);
    acc(1'b0, 8'h04, 32'h0);
    check("rx ready clear", rd[3], 1'h0);
    repeat (6000) @(posedge i_clk);
    acc(1'b0, 8'h10, 32'h0);
    check("rx freq", rd[15:0] inside {[16'h7C:16'h7E]}, 1'h1);
    check("tone present", o_notone, 1'h0);
    $display("test receive done");
    src_en <= 1'b0;
    wait_st(2, 1'b1);
    check("no tone", o_notone, 1'h1);
    acc(1'b1, 8'h00, 32'h20);
    acc(1'b1, 8'h04, 32'h4);
    repeat (1500) @(posedge i_clk);
    check("timer idle", o_irq, 1'h0);
    $display("test tone absence done");
    end_sim();
  end
endmodule : stnc_core_tb
